// ### logic/flag_clear_bank.sv
// Read-to-clear flag bank of a two-wire bus controller, with its raw event word,
// abort cause record, transmit FIFO hold and a maskable interrupt.
// Assumes the bus engine gives one-cycle event pulses and level busy/enable inputs,
// all synchronous to sys_clk, and a classic Wishbone master on the register side.
// Every request is answered one cycle after it is taken; the bank never stalls.
// Only byte lanes 0 and 1 reach the writable registers.
// Software clears flags by reading; writes to clear registers are ignored.
`timescale 1ns/100ps

module flag_clear_bank (
    input  wire logic        sys_clk,                // System clock, 200 MHz
    input  wire logic        resetn,                 // Asynchronous reset, active low
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,               // Bus cycle
    input  wire logic        wb_stb_i,               // Strobe
    input  wire logic        wb_we_i,                // Write enable
    input  wire logic [31:0] wb_adr_i,               // Byte address
    input  wire logic [3:0]  wb_sel_i,               // Byte lanes
    input  wire logic [31:0] wb_dat_i,               // Write data
    output logic      [31:0] wb_dat_o,               // Read data
    output logic             wb_ack_o,               // Acknowledge

    // Events from the bus engine, one-cycle pulses
    input  wire logic        tx_overflow_event,      // Transmit FIFO overrun
    input  wire logic        read_request_event,     // Remote master wants data
    input  wire logic        tx_abort_event,         // Transfer aborted
    input  wire logic [15:0] abort_cause_in,         // Cause bits with the abort
    input  wire logic        rx_done_event,          // Slave transmit finished
    input  wire logic        bus_activity_event,     // Any bus activity seen
    input  wire logic        stop_condition_event,   // Stop seen
    input  wire logic        start_condition_event,  // Start or restart seen
    input  wire logic        general_call_event,     // General call received

    // Engine levels
    input  wire logic        controller_busy,        // Engine engaged on the bus
    input  wire logic        controller_enabled,     // Controller enable level
    input  wire logic        abort_sticky_hold,      // Keep cause bit 9 on clear

    // Outputs to the rest of the controller
    output logic      [15:0] raw_event_status_word,  // Raw event flags
    output logic      [15:0] abort_cause_record,     // Causes of all aborts since the last clear
    output logic             tx_fifo_flush_hold,     // Transmit FIFO held flushed
    output logic             irq                     // Level interrupt
);

    // ****************************************
    // Bus decode
    // ****************************************

    // Request decode
    logic        access;                             // New request this cycle
    logic        rd_access;                          // New read this cycle
    logic        wr_access;                          // New write this cycle

    // Flag paths
    logic [15:0] clear_read;                         // One-hot per flag, read now
    logic [15:0] event_set;                          // Event pulses in flag layout
    logic [15:0] read_value;                         // Data for the current read
    logic [15:0] flag_next;                          // Next raw flag word

    // Interrupt registers
    logic [15:0] irq_status_reg;                     // Sticky interrupt status
    logic [15:0] irq_mask_reg;                       // Interrupt mask

    // Abort and write paths
    logic [15:0] abort_next;                         // Next abort cause record
    logic [15:0] write_data;                         // Write data, lanes applied

    // Take each request once; ack is high for exactly one cycle
    // A master that keeps strobe up through the ack cycle
    // is not served twice for one transfer
    assign access    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_access = access & ~wb_we_i;
    assign wr_access = access & wb_we_i;

    // Byte lanes applied to the low half word
    // Lanes 2 and 3 carry no register bits
    assign write_data = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                         wb_sel_i[0] ? wb_dat_i[7:0]  : 8'h00};

    // Selects a flag whose clear register was read this cycle
    // True for a read of the given address taken now
    function automatic logic read_of(input logic [31:0] adr);
        read_of = rd_access && (wb_adr_i == adr);
    endfunction : read_of

    // ****************************************
    // Clear strobes and event layout
    // ****************************************

    // Map each clear register read onto its flag position
    always_comb begin
        clear_read = 16'h0000;

        // Transmit overflow
        clear_read[flag_clear_pkg::TX_OVERFLOW_POS] =
            read_of(flag_clear_pkg::TX_OVERFLOW_FLAG_CLEAR_ADDR);

        // Read request
        clear_read[flag_clear_pkg::READ_REQUEST_POS] =
            read_of(flag_clear_pkg::READ_REQUEST_FLAG_CLEAR_ADDR);

        // Transmit abort
        clear_read[flag_clear_pkg::TX_ABORT_POS] =
            read_of(flag_clear_pkg::TX_ABORT_FLAG_CLEAR_ADDR);

        // Receive done
        clear_read[flag_clear_pkg::RX_DONE_POS] =
            read_of(flag_clear_pkg::RX_DONE_FLAG_CLEAR_ADDR);

        // Activity, only once the engine is idle
        clear_read[flag_clear_pkg::BUS_ACTIVITY_POS] =
            read_of(flag_clear_pkg::BUS_ACTIVITY_FLAG_CLEAR_ADDR)
            & ~controller_busy;

        // Stop condition
        clear_read[flag_clear_pkg::STOP_CONDITION_POS] =
            read_of(flag_clear_pkg::STOP_CONDITION_FLAG_CLEAR_ADDR);

        // Start condition
        clear_read[flag_clear_pkg::START_CONDITION_POS] =
            read_of(flag_clear_pkg::START_CONDITION_FLAG_CLEAR_ADDR);

        // General call
        clear_read[flag_clear_pkg::GENERAL_CALL_POS] =
            read_of(flag_clear_pkg::GENERAL_CALL_FLAG_CLEAR_ADDR);
    end

    // Gather engine events into the flag layout
    always_comb begin
        event_set = 16'h0000;

        // Transfer events
        event_set[flag_clear_pkg::TX_OVERFLOW_POS]     = tx_overflow_event;
        event_set[flag_clear_pkg::READ_REQUEST_POS]    = read_request_event;
        event_set[flag_clear_pkg::TX_ABORT_POS]        = tx_abort_event;
        event_set[flag_clear_pkg::RX_DONE_POS]         = rx_done_event;

        // Bus condition events
        event_set[flag_clear_pkg::BUS_ACTIVITY_POS]    = bus_activity_event;
        event_set[flag_clear_pkg::STOP_CONDITION_POS]  = stop_condition_event;
        event_set[flag_clear_pkg::START_CONDITION_POS] = start_condition_event;
        event_set[flag_clear_pkg::GENERAL_CALL_POS]    = general_call_event;
    end

    // ****************************************
    // Raw event flags
    // ****************************************

    // Clear on read, then set by the event; a same-cycle event wins
    // A controller disabled while busy keeps activity until it goes idle
    always_comb begin
        flag_next = (raw_event_status_word & ~clear_read) | event_set;

        // Activity drops by itself once disabled and idle, unless newly seen
        if (!controller_enabled && !controller_busy && !bus_activity_event) begin
            flag_next[flag_clear_pkg::BUS_ACTIVITY_POS] = 1'b0;
        end

        // Positions outside the field never set
        flag_next = flag_next & flag_clear_pkg::FLAG_FIELD_MASK;
    end

    // Raw flag register
    // Reset leaves every flag low
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            raw_event_status_word <= flag_clear_pkg::RAW_STATUS_RESET;
        end else begin
            raw_event_status_word <= flag_next;
        end
    end

    // ****************************************
    // Abort cause and transmit FIFO hold
    // ****************************************

    // Clearing keeps cause bit 9 while the engine holds it; a new abort ORs its cause bits in
    always_comb begin
        abort_next = abort_cause_record;
        if (clear_read[flag_clear_pkg::TX_ABORT_POS]) begin
            // Clear read zeroes the record
            abort_next = 16'h0000;
            // Engine may keep cause bit 9 alive
            if (abort_sticky_hold) begin
                abort_next[flag_clear_pkg::ABORT_STICKY_POS] =
                    abort_cause_record[flag_clear_pkg::ABORT_STICKY_POS];
            end
        end

        // New cause bits land after the clear
        if (tx_abort_event) begin
            abort_next = abort_next | abort_cause_in;
        end
    end

    // Abort cause record
    // Reset leaves no cause recorded
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            abort_cause_record <= flag_clear_pkg::ABORT_CAUSE_RESET;
        end else begin
            abort_cause_record <= abort_next;
        end
    end

    // Transmit FIFO is held flushed from an abort until the abort clear read
    // An abort in the same cycle as the clear keeps the hold
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_fifo_flush_hold <= 1'b0;
        end else if (tx_abort_event) begin
            // New abort flushes and holds the FIFO
            tx_fifo_flush_hold <= 1'b1;
        end else if (clear_read[flag_clear_pkg::TX_ABORT_POS]) begin
            // Software may write the FIFO again
            tx_fifo_flush_hold <= 1'b0;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************

    // Sticky status, write one to clear; a new event beats the clear
    // Status bits follow the events, not the raw flag clears
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_status_reg <= 16'h0000;
        end else if (wr_access && wb_adr_i == flag_clear_pkg::IRQ_STATUS_ADDR) begin
            // Ones written clear, events still land
            irq_status_reg <= (irq_status_reg & ~write_data) | event_set;
        end else begin
            // Only events change the status
            irq_status_reg <= irq_status_reg | event_set;
        end
    end

    // Mask register, one enables the matching status bit
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask_reg <= flag_clear_pkg::IRQ_MASK_RESET;
        end else if (wr_access && wb_adr_i == flag_clear_pkg::IRQ_MASK_ADDR) begin
            // Only flag positions can be enabled
            irq_mask_reg <= write_data & flag_clear_pkg::FLAG_FIELD_MASK;
        end
    end

    // Interrupt output, registered from status and mask
    // so it trails a new event by two edges
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ****************************************
    // Read data and acknowledge
    // ****************************************

    // Clear registers return their flag before the clear in bit 0
    // The mux sees the flags as they stand before this edge, so a read
    // still reports the flag that its own clear is about to drop
    always_comb begin
        read_value = 16'h0000;

        case (wb_adr_i)
            // Overflow clear
            flag_clear_pkg::TX_OVERFLOW_FLAG_CLEAR_ADDR: begin
                read_value[0] = raw_event_status_word[flag_clear_pkg::TX_OVERFLOW_POS];
            end

            // Read request clear
            flag_clear_pkg::READ_REQUEST_FLAG_CLEAR_ADDR: begin
                read_value[0] = raw_event_status_word[flag_clear_pkg::READ_REQUEST_POS];
            end

            // Abort clear
            flag_clear_pkg::TX_ABORT_FLAG_CLEAR_ADDR: begin
                read_value[0] = raw_event_status_word[flag_clear_pkg::TX_ABORT_POS];
            end

            // Receive done clear
            flag_clear_pkg::RX_DONE_FLAG_CLEAR_ADDR: begin
                read_value[0] = raw_event_status_word[flag_clear_pkg::RX_DONE_POS];
            end

            // Activity clear
            flag_clear_pkg::BUS_ACTIVITY_FLAG_CLEAR_ADDR: begin
                read_value[0] = raw_event_status_word[flag_clear_pkg::BUS_ACTIVITY_POS];
            end

            // Stop clear
            flag_clear_pkg::STOP_CONDITION_FLAG_CLEAR_ADDR: begin
                read_value[0] = raw_event_status_word[flag_clear_pkg::STOP_CONDITION_POS];
            end

            // Start clear
            flag_clear_pkg::START_CONDITION_FLAG_CLEAR_ADDR: begin
                read_value[0] =
                    raw_event_status_word[flag_clear_pkg::START_CONDITION_POS];
            end

            // General call clear
            flag_clear_pkg::GENERAL_CALL_FLAG_CLEAR_ADDR: begin
                read_value[0] = raw_event_status_word[flag_clear_pkg::GENERAL_CALL_POS];
            end

            // Raw flag word
            flag_clear_pkg::RAW_EVENT_STATUS_ADDR: begin
                read_value = raw_event_status_word;
            end

            // Interrupt status
            flag_clear_pkg::IRQ_STATUS_ADDR: begin
                read_value = irq_status_reg;
            end

            // Interrupt mask
            flag_clear_pkg::IRQ_MASK_ADDR: begin
                read_value = irq_mask_reg;
            end

            // Abort cause record
            flag_clear_pkg::ABORT_CAUSE_ADDR: begin
                read_value = abort_cause_record;
            end

            // Anything else
            default: begin
                read_value = 16'h0000;                                      // Unmapped reads zero
            end
        endcase
    end

    // Acknowledge one cycle after the request, for one cycle
    // Writes are answered the same way, also where they are ignored
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            // One pulse per taken request
            wb_ack_o <= access;
        end
    end

    // Read data latched with the acknowledge; writes and idle give zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h00000000;
        end else if (rd_access) begin
            // Read taken: selected register in the low half
            wb_dat_o <= {16'h0000, read_value};
        end else begin
            // Writes and idle cycles read zero
            wb_dat_o <= 32'h00000000;
        end
    end

endmodule : flag_clear_bank

// ### logic/flag_clear_pkg.sv
// Package of the read-to-clear flag bank: addresses, flag positions and reset values.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package flag_clear_pkg;

    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [31:0] TX_OVERFLOW_FLAG_CLEAR_ADDR    = 32'h5000134c;
    localparam logic [31:0] READ_REQUEST_FLAG_CLEAR_ADDR   = 32'h50001350;
    localparam logic [31:0] TX_ABORT_FLAG_CLEAR_ADDR       = 32'h50001354;
    localparam logic [31:0] RX_DONE_FLAG_CLEAR_ADDR        = 32'h50001358;
    localparam logic [31:0] BUS_ACTIVITY_FLAG_CLEAR_ADDR   = 32'h5000135c;
    localparam logic [31:0] STOP_CONDITION_FLAG_CLEAR_ADDR = 32'h50001360;
    localparam logic [31:0] START_CONDITION_FLAG_CLEAR_ADDR = 32'h50001364;
    localparam logic [31:0] GENERAL_CALL_FLAG_CLEAR_ADDR   = 32'h50001368;
    localparam logic [31:0] RAW_EVENT_STATUS_ADDR          = 32'h50001380;
    localparam logic [31:0] IRQ_STATUS_ADDR                = 32'h50001384;
    localparam logic [31:0] IRQ_MASK_ADDR                  = 32'h50001388;
    localparam logic [31:0] ABORT_CAUSE_ADDR               = 32'h5000138c;

    // ****************************************
    // Positions in the raw event status word
    // ****************************************
    localparam int TX_OVERFLOW_POS     = 3;
    localparam int READ_REQUEST_POS    = 5;
    localparam int TX_ABORT_POS        = 6;
    localparam int RX_DONE_POS         = 7;
    localparam int BUS_ACTIVITY_POS    = 8;
    localparam int STOP_CONDITION_POS  = 9;
    localparam int START_CONDITION_POS = 10;
    localparam int GENERAL_CALL_POS    = 11;

    // Abort cause bit that survives a clear while its hold input is high
    localparam int ABORT_STICKY_POS    = 9;

    // ****************************************
    // Widths and reset values
    // ****************************************
    localparam int          REG_WIDTH          = 16;
    localparam logic [15:0] RAW_STATUS_RESET   = 16'h0000;
    localparam logic [15:0] ABORT_CAUSE_RESET  = 16'h0000;
    localparam logic [15:0] IRQ_MASK_RESET     = 16'h0000;
    localparam logic [15:0] FLAG_FIELD_MASK    = 16'h0fe8;

endpackage : flag_clear_pkg

// ### tb/flag_clear_bank_props.sv
// Checker of the read-to-clear flag bank: clears, abort release, activity rules.
// Assumes it is bound to flag_clear_bank and sees only that module's ports.
`timescale 1ns/100ps

module flag_clear_bank_props (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        tx_overflow_event,
    input wire logic        read_request_event,
    input wire logic        tx_abort_event,
    input wire logic        rx_done_event,
    input wire logic        bus_activity_event,
    input wire logic        stop_condition_event,
    input wire logic        start_condition_event,
    input wire logic        general_call_event,
    input wire logic        controller_busy,
    input wire logic        controller_enabled,
    input wire logic [15:0] raw_event_status_word,
    input wire logic [15:0] abort_cause_record,
    input wire logic        tx_fifo_flush_hold
);
    // ****************************************
    // Helpers
    // ****************************************
    logic [7:0] ra;  // Low address byte of a read taken in the bank page, else zero
    assign ra = (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
                 && wb_adr_i[31:8] == 24'h500013) ? wb_adr_i[7:0] : 8'h00;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // ****************************************
    // Assertions
    // ****************************************
    chk_tx_over_clear: assert property (ra == 8'h4c && !tx_overflow_event |=>
        !raw_event_status_word[3]) else $error("overflow flag kept after read");
    chk_rd_req_clear: assert property (ra == 8'h50 && !read_request_event |=>
        !raw_event_status_word[5]) else $error("read request flag kept after read");
    chk_abort_clear: assert property (ra == 8'h54 && !tx_abort_event |=>
        !raw_event_status_word[6] && (abort_cause_record & 16'hfdff) == 16'h0000)
        else $error("abort flag or cause kept after read");
    chk_fifo_release: assert property (ra == 8'h54 && !tx_abort_event ##1 1'b1 |->
        !tx_fifo_flush_hold) else $error("transmit hold kept after abort read");
    chk_rx_done_clear: assert property (ra == 8'h58 && !rx_done_event |=>
        !raw_event_status_word[7]) else $error("receive done flag kept after read");
    chk_idle_act_clear: assert property (ra == 8'h5c && !controller_busy
        && !bus_activity_event |=> !raw_event_status_word[8])
        else $error("activity flag kept after idle read");
    chk_busy_act_keep: assert property (controller_busy && raw_event_status_word[8]
        |=> raw_event_status_word[8]) else $error("activity flag dropped while busy");
    chk_act_auto_clear: assert property (!controller_enabled && !controller_busy
        && !bus_activity_event |=> !raw_event_status_word[8])
        else $error("activity flag not self cleared");
    chk_act_read_value: assert property (ra == 8'h5c |=>
        wb_dat_o[0] == $past(raw_event_status_word[8])) else $error("activity read value");
    chk_start_clear: assert property (ra == 8'h64 && !start_condition_event |=>
        !raw_event_status_word[10]) else $error("start flag kept after read");
    chk_gen_call_clear: assert property (ra == 8'h68 && !general_call_event |=>
        !raw_event_status_word[11]) else $error("general call flag kept after read");
    chk_stop_clear: assert property (ra == 8'h60 && !stop_condition_event |=>
        !raw_event_status_word[9]) else $error("stop flag kept after read");
    chk_upper_zero: assert property (ra >= 8'h4c && ra <= 8'h68 |=>
        wb_dat_o[31:1] == 31'h0) else $error("clear register upper bits not zero");

    // Main scenarios seen
    cov_abort: cover property (ra == 8'h54 && tx_fifo_flush_hold);
    cov_busy_read: cover property (ra == 8'h5c && controller_busy);
    cov_auto: cover property (!controller_enabled && $fell(raw_event_status_word[8]));
endmodule : flag_clear_bank_props

bind flag_clear_bank flag_clear_bank_props chk (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .tx_overflow_event, .read_request_event,
    .tx_abort_event, .rx_done_event, .bus_activity_event, .stop_condition_event,
    .start_condition_event, .general_call_event, .controller_busy, .controller_enabled,
    .raw_event_status_word, .abort_cause_record, .tx_fifo_flush_hold);

// ### tb/flag_clear_bank_tb.sv
// Bench of the read-to-clear flag bank: random event and clear traffic over Wishbone.
// Assumes flag_clear_pkg, the design and its bound checker are compiled first.
`timescale 1ns/100ps

module flag_clear_bank_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic [7:0]  evt = 8'h00;                // Event pulses, one bit per flag
    logic [15:0] cause = 16'h0000, c, erec = 16'h0000;  // Abort cause, expected record
    logic        busy = 1'b0, en = 1'b1, hold = 1'b0, wb_ack_o, flush, irq;
    logic [15:0] raw, rec;
    int          mismatches = 0, n_compared = 0, k, i;
    int          pos [8] = '{3, 5, 6, 7, 8, 9, 10, 11};  // Flag bit of each event
    logic [7:0]  ofs [8] = '{8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68};

    always #2.5 sys_clk = ~sys_clk;  // 200 MHz

    flag_clear_bank uut (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i(4'h3), .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_overflow_event(evt[0]),
        .read_request_event(evt[1]), .tx_abort_event(evt[2]), .abort_cause_in(cause),
        .rx_done_event(evt[3]), .bus_activity_event(evt[4]), .stop_condition_event(evt[5]),
        .start_condition_event(evt[6]), .general_call_event(evt[7]),
        .controller_busy(busy), .controller_enabled(en), .abort_sticky_hold(hold),
        .raw_event_status_word(raw), .abort_cause_record(rec), .tx_fifo_flush_hold(flush),
        .irq);

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask : check

    task automatic tally_and_finish();
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // One classic cycle; holds the request until ack is sampled high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        #1;
    endtask : xfer

    // One-cycle event pulse with its abort cause and sticky hold level
    task automatic pulse(input int j, input logic [15:0] cv, input logic h);
        @(posedge sys_clk);
        evt <= 8'h01 << j;
        cause <= cv;
        hold <= h;
        @(posedge sys_clk);
        evt <= 8'h00;
        #1;
    endtask : pulse

    // Record left by an abort clear: only the sticky bit may survive
    function automatic logic [15:0] exp_cause(input logic [15:0] r, input logic h);
        return h ? (r & 16'h0200) : 16'h0000;
    endfunction : exp_cause

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(28453));
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        for (i = 0; i < 8; i++) begin
            xfer(1'b0, {24'h500013, ofs[i]}, 32'h0);
            check("reset read", 32'h0, rdat);
        end
        // Every flag once, then random picks
        for (k = 0; k < 24; k++) begin
            i = (k < 8) ? k : $urandom_range(7);
            c = 16'($urandom);
            pulse(i, c, 1'($urandom));
            if (i == 2) erec = erec | c;
            xfer(1'b1, {24'h500013, ofs[i]}, $urandom);
            check("flag after write", 32'h1, 32'(raw[pos[i]]));
            if (i == 2) check("cause", 32'(erec), 32'(rec));
            if (i == 2) check("hold set", 32'h1, 32'(flush));
            xfer(1'b0, {24'h500013, ofs[i]}, 32'h0);
            check("clear read", 32'h1, rdat);
            check("flag cleared", 32'h0, 32'(raw[pos[i]]));
            erec = (i == 2) ? exp_cause(erec, hold) : erec;
            check("cause cleared", 32'(erec), 32'(rec));
            check("hold released", 32'h0, 32'(flush));
        end
        // Corner: an event in the cycle of its clear read keeps the flag
        fork
            pulse(0, 16'h0, 1'b0);
            xfer(1'b0, {24'h500013, ofs[0]}, 32'h0);
        join
        check("set wins", 32'h1, 32'(raw[3]));
        // Activity read while busy, then idle
        @(posedge sys_clk);
        busy <= 1'b1;
        pulse(4, 16'h0, 1'b0);
        xfer(1'b0, {24'h500013, ofs[4]}, 32'h0);
        check("busy read", 32'h1, rdat);
        check("busy flag", 32'h1, 32'(raw[8]));
        @(posedge sys_clk);
        busy <= 1'b0;
        xfer(1'b0, {24'h500013, ofs[4]}, 32'h0);
        check("idle flag", 32'h0, 32'(raw[8]));
        // Self clear once disabled and idle
        pulse(4, 16'h0, 1'b0);
        @(posedge sys_clk);
        en <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("auto clear", 32'h0, 32'(raw[8]));
        @(posedge sys_clk);
        en <= 1'b1;
        // Interrupt: clear pending, mask in, raise, clear, mask out
        xfer(1'b1, flag_clear_pkg::IRQ_STATUS_ADDR, 32'h0fe8);
        xfer(1'b1, flag_clear_pkg::IRQ_MASK_ADDR, 32'hffff);
        xfer(1'b0, flag_clear_pkg::IRQ_MASK_ADDR, 32'h0);
        check("mask", 32'h0fe8, rdat);
        pulse(0, 16'h0, 1'b0);
        @(posedge sys_clk);
        #1;
        check("irq high", 32'h1, 32'(irq));
        xfer(1'b1, flag_clear_pkg::IRQ_STATUS_ADDR, 32'h0008);
        check("irq low", 32'h0, 32'(irq));
        xfer(1'b1, flag_clear_pkg::IRQ_MASK_ADDR, 32'h0);
        pulse(1, 16'h0, 1'b0);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq masked", 32'h0, 32'(irq));
        xfer(1'b0, flag_clear_pkg::IRQ_STATUS_ADDR, 32'h0);
        check("irq status", 32'h0020, rdat);
        xfer(1'b0, flag_clear_pkg::RAW_EVENT_STATUS_ADDR, 32'h0);
        check("raw word", 32'h0028, rdat);
        xfer(1'b0, flag_clear_pkg::ABORT_CAUSE_ADDR, 32'h0);
        check("cause word", 32'(erec), rdat);
        xfer(1'b0, 32'h50001390, 32'h0);
        check("unmapped", 32'h0, rdat);
        tally_and_finish();
    end
endmodule : flag_clear_bank_tb
